/* File: hw/ep0ar_pkg.sv */
package ep0ar_pkg;
	// Link token kinds sent by the host end
	typedef enum logic [2:0] {
		TOK_SETUP = 3'h0,
		TOK_IN = 3'h1,
		TOK_STATUS = 3'h2,
		TOK_ACK = 3'h3,
		TOK_ERR = 3'h4
	} ep0ar_tok_t;
	// Device answers to a token
	typedef enum logic [1:0] {
		RSP_ACK = 2'h0,
		RSP_NAK = 2'h1,
		RSP_STALL = 2'h2,
		RSP_ZLP = 2'h3
	} ep0ar_rsp_t;
	// Device engine states
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_CALC = 3'h1,
		D_WAIT_IN = 3'h2,
		D_FILL = 3'h3,
		D_WAIT_HS = 3'h4,
		D_STATUS = 3'h5
	} ep0ar_dstate_t;
	// Host end states
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SETUP = 3'h1,
		H_IN = 3'h2,
		H_RX = 3'h3,
		H_SEND_ST = 3'h4,
		H_STATUS = 3'h5
	} ep0ar_hstate_t;
	// Firmware port map (9-bit byte address)
	localparam logic [8:0] REG_PTR_HI = 9'h100;
	localparam logic [8:0] REG_PTR_LO = 9'h101;
	localparam logic [8:0] REG_EP0CS = 9'h102;
	localparam logic [8:0] REG_IN_BC = 9'h103;
	localparam logic [8:0] REG_WAKE = 9'h104;
	localparam logic [8:0] REG_STALL_OUT = 9'h105;
	localparam logic [8:0] REG_STALL_IN = 9'h106;
	localparam logic [8:0] REG_TOGGLE = 9'h107;
	localparam logic [8:0] SETUP_BASE = 9'h108;
	localparam logic [8:0] INBUF_BASE = 9'h140;
	// Control/status field positions
	localparam int CS_STALL = 0;
	localparam int CS_HANDSHAKE_NAK_HOLD = 1;
	localparam int CS_BUSY = 2;
	localparam int RT_DIR_IN = 7;
	// Descriptor type whose length is a 16-bit total at bytes 2..3
	localparam logic [7:0] CFG_DESC_TYPE = 8'h02;
	// Largest endpoint-zero packet
	localparam logic [6:0] PKT_MAX = 7'h40;
	localparam logic [15:0] PKT_MAX_W = 16'h0040;
	// Reset values
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] STALL_RST = 8'h00;
	// Data FIFO shape: byte plus last flag, eight entries
	localparam int FIFO_W = 9;
	localparam int FIFO_D = 8;
endpackage : ep0ar_pkg

/* File: hw/ep0ar_link_if.sv */
`timescale 1ns/10ps
interface ep0ar_link_if (
	input wire logic clk_sys
);
	logic tok_valid; // One-cycle token strobe from host
	ep0ar_pkg::ep0ar_tok_t tok_kind;
	logic [63:0] tok_setup; // SETUP bytes, byte 0 in bits 7:0
	logic d2h_valid; // Data byte stream from device
	logic d2h_ready;
	logic [7:0] d2h_data;
	logic d2h_last; // Last byte of a packet
	logic d2h_toggle; // DATA0/DATA1 of the current packet
	logic rsp_valid; // One-cycle handshake answer
	ep0ar_pkg::ep0ar_rsp_t rsp_code;
	modport dev (
		input tok_valid,
		input tok_kind,
		input tok_setup,
		input d2h_ready,
		output d2h_valid,
		output d2h_data,
		output d2h_last,
		output d2h_toggle,
		output rsp_valid,
		output rsp_code
	);
	modport hst (
		output tok_valid,
		output tok_kind,
		output tok_setup,
		output d2h_ready,
		input d2h_valid,
		input d2h_data,
		input d2h_last,
		input d2h_toggle,
		input rsp_valid,
		input rsp_code
	);
endinterface : ep0ar_link_if

/* File: hw/ep0ar_fifo.sv */
`timescale 1ns/10ps
module ep0ar_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// Depth must be a power of two so the pointers wrap by themselves
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} ep0ar_fifo_t;
	ep0ar_fifo_t r_reg; // Pointers and fill level
	ep0ar_fifo_t r_next;
	logic [W-1:0] mem [D]; // Storage, no reset needed
	logic push;
	logic pop;

	// Honest full and empty from the fill level
	assign in_ready = (r_reg.cnt != FULL);
	assign out_valid = (r_reg.cnt != '0);
	assign out_data = mem[r_reg.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next pointers; flush drops everything, winning over a push
	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.wp = r_reg.wp + 1'b1;
		end
		if (pop) begin
			r_next.rp = r_reg.rp + 1'b1;
		end
		r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			r_next = '0;
		end
	end

	// Register the pointers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Write port of the storage
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[r_reg.wp] <= in_data;
		end
	end
endmodule : ep0ar_fifo

/* File: hw/ep0ar_device.sv */
`timescale 1ns/10ps
module ep0ar_device (
	input wire logic clk_sys,
	input wire logic sys_rst,
	ep0ar_link_if.dev link,
	input wire logic fw_wr,
	input wire logic [8:0] fw_addr,
	input wire logic [7:0] fw_wdata,
	output logic [7:0] fw_rdata,
	output logic setup_data_available_irq,
	output logic ep_zero_in_irq,
	output logic remote_wakeup_en
);
	typedef struct packed {
		ep0ar_pkg::ep0ar_dstate_t st;
		logic [15:0] ptr; // setup_data_pointer
		logic stall0; // Endpoint-zero stall
		logic handshake_nak_hold; // handshake_nak_hold
		logic [6:0] in_bc; // ep_zero_in_byte_count
		logic wake;
		logic [7:0] stall_out;
		logic [7:0] stall_in;
		logic toggle; // Endpoint-zero data toggle
		logic [63:0] setup; // setup_packet_ram
		logic [15:0] addr; // Next byte to fetch
		logic [15:0] base; // First byte of current packet
		logic [15:0] remain; // Bytes still unacknowledged
		logic [6:0] pkt_len;
		logic [6:0] pkt_cnt;
		logic src_buf; // Fetch from IN buffer, not table
		logic [7:0] rdata;
		logic sud_irq;
		logic in_irq;
		logic rsp_valid;
		ep0ar_pkg::ep0ar_rsp_t rsp_code;
	} ep0ar_dev_t;
	ep0ar_dev_t r_reg;
	ep0ar_dev_t r_next;
	logic [7:0] desc_ram [256]; // Descriptor tables
	logic [7:0] in_buf [64]; // ep_zero_in_buffer
	logic [7:0] i0; // Table indices around the pointer
	logic [7:0] i1;
	logic [7:0] i2;
	logic [7:0] i3;
	logic [15:0] dlen; // Descriptor's own length
	logic [15:0] wlen; // Requested length
	logic [7:0] fetch;
	logic f_last;
	logic f_push;
	logic f_ready;
	logic flush;
	logic [8:0] f_out;

	assign i0 = r_reg.ptr[7:0];
	assign i1 = i0 + 8'h01;
	assign i2 = i0 + 8'h02;
	assign i3 = i0 + 8'h03;
	assign wlen = r_reg.setup[63:48];
	// Configuration tables carry a 16-bit total; others a length byte
	assign dlen = (desc_ram[i1] == ep0ar_pkg::CFG_DESC_TYPE) ?
		{desc_ram[i3], desc_ram[i2]} : {8'h00, desc_ram[i0]};
	// Byte source: table at consecutive addresses, or firmware buffer
	assign fetch = r_reg.src_buf ? in_buf[r_reg.addr[5:0]] : desc_ram[r_reg.addr[7:0]];
	assign f_last = (r_reg.pkt_cnt == (r_reg.pkt_len - 7'h01));
	assign f_push = (r_reg.st == ep0ar_pkg::D_FILL) && f_ready;
	// A fresh SETUP throws away any bytes still queued
	assign flush = link.tok_valid && (link.tok_kind == ep0ar_pkg::TOK_SETUP);

	// Queue between fetch engine and link; host back-pressure stalls FILL
	ep0ar_fifo #(
		.W(ep0ar_pkg::FIFO_W),
		.D(ep0ar_pkg::FIFO_D)
	) u_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.flush(flush),
		.in_valid(r_reg.st == ep0ar_pkg::D_FILL),
		.in_ready(f_ready),
		.in_data({f_last, fetch}),
		.out_valid(link.d2h_valid),
		.out_ready(link.d2h_ready),
		.out_data(f_out)
	);
	assign link.d2h_data = f_out[7:0];
	assign link.d2h_last = f_out[8];
	assign link.d2h_toggle = r_reg.toggle;
	assign link.rsp_valid = r_reg.rsp_valid;
	assign link.rsp_code = r_reg.rsp_code;
	assign fw_rdata = r_reg.rdata;
	assign setup_data_available_irq = r_reg.sud_irq;
	assign ep_zero_in_irq = r_reg.in_irq;
	assign remote_wakeup_en = r_reg.wake;

	// Next state: firmware writes first, link tokens after so they win
	always_comb begin
		r_next = r_reg;
		r_next.sud_irq = 1'b0;
		r_next.in_irq = 1'b0;
		r_next.rsp_valid = 1'b0;
		// Registered read data; reserved addresses read zero
		r_next.rdata = 8'h00;
		if (fw_addr < ep0ar_pkg::REG_PTR_HI) begin
			r_next.rdata = desc_ram[fw_addr[7:0]];
		end else if (fw_addr >= ep0ar_pkg::INBUF_BASE && fw_addr < ep0ar_pkg::INBUF_BASE + 9'h040) begin
			r_next.rdata = in_buf[fw_addr[5:0]];
		end else if (fw_addr >= ep0ar_pkg::SETUP_BASE && fw_addr < ep0ar_pkg::SETUP_BASE + 9'h008) begin
			r_next.rdata = r_reg.setup[8*fw_addr[2:0] +: 8];
		end else begin
			case (fw_addr)
				ep0ar_pkg::REG_PTR_HI: r_next.rdata = r_reg.ptr[15:8];
				ep0ar_pkg::REG_PTR_LO: r_next.rdata = r_reg.ptr[7:0];
				ep0ar_pkg::REG_EP0CS: begin
					r_next.rdata[ep0ar_pkg::CS_STALL] = r_reg.stall0;
					r_next.rdata[ep0ar_pkg::CS_HANDSHAKE_NAK_HOLD] = r_reg.handshake_nak_hold;
					r_next.rdata[ep0ar_pkg::CS_BUSY] = (r_reg.st != ep0ar_pkg::D_IDLE);
				end
				ep0ar_pkg::REG_IN_BC: r_next.rdata = {1'b0, r_reg.in_bc};
				ep0ar_pkg::REG_WAKE: r_next.rdata = {7'h00, r_reg.wake};
				ep0ar_pkg::REG_STALL_OUT: r_next.rdata = r_reg.stall_out;
				ep0ar_pkg::REG_STALL_IN: r_next.rdata = r_reg.stall_in;
				ep0ar_pkg::REG_TOGGLE: r_next.rdata = {7'h00, r_reg.toggle};
				default: r_next.rdata = 8'h00;
			endcase
		end
		// Firmware register writes
		if (fw_wr) begin
			case (fw_addr)
				ep0ar_pkg::REG_PTR_HI: r_next.ptr[15:8] = fw_wdata;
				ep0ar_pkg::REG_PTR_LO: begin
					r_next.ptr[7:0] = fw_wdata;
					r_next.src_buf = 1'b0;
					r_next.st = ep0ar_pkg::D_CALC;
				end
				ep0ar_pkg::REG_EP0CS: begin
					r_next.stall0 = fw_wdata[ep0ar_pkg::CS_STALL];
					// Write one to release the NAK hold
					if (fw_wdata[ep0ar_pkg::CS_HANDSHAKE_NAK_HOLD]) begin
						r_next.handshake_nak_hold = 1'b0;
					end
				end
				ep0ar_pkg::REG_IN_BC: begin
					// Counts above one packet are clipped to one packet
					r_next.in_bc = (fw_wdata > 8'h40) ? ep0ar_pkg::PKT_MAX : fw_wdata[6:0];
					r_next.src_buf = 1'b1;
					r_next.addr = 16'h0000;
					r_next.remain = {9'h000, r_next.in_bc};
					r_next.st = (r_next.in_bc == 7'h00) ? ep0ar_pkg::D_STATUS : ep0ar_pkg::D_WAIT_IN;
				end
				ep0ar_pkg::REG_WAKE: r_next.wake = fw_wdata[0];
				ep0ar_pkg::REG_STALL_OUT: r_next.stall_out = fw_wdata;
				ep0ar_pkg::REG_STALL_IN: r_next.stall_in = fw_wdata;
				// Firmware may only force the toggle back to DATA0
				ep0ar_pkg::REG_TOGGLE: if (fw_wdata[0]) r_next.toggle = 1'b0;
				default: ;
			endcase
		end
		// Engine sequencing
		case (r_reg.st)
			ep0ar_pkg::D_CALC: begin
				// Shorter of requested and actual length
				r_next.remain = (dlen < wlen) ? dlen : wlen;
				r_next.addr = r_reg.ptr;
				r_next.st = (r_next.remain == 16'h0000) ? ep0ar_pkg::D_STATUS : ep0ar_pkg::D_WAIT_IN;
			end
			ep0ar_pkg::D_FILL: begin
				if (f_push) begin
					r_next.addr = r_reg.addr + 16'h0001;
					r_next.pkt_cnt = r_reg.pkt_cnt + 7'h01;
					if (f_last) begin
						r_next.st = ep0ar_pkg::D_WAIT_HS;
					end
				end
			end
			default: ;
		endcase
		// Link tokens
		if (link.tok_valid) begin
			r_next.rsp_valid = 1'b1;
			r_next.rsp_code = ep0ar_pkg::RSP_NAK;
			case (link.tok_kind)
				ep0ar_pkg::TOK_SETUP: begin
					r_next.setup = link.tok_setup;
					r_next.sud_irq = 1'b1;
					r_next.handshake_nak_hold = 1'b1;
					r_next.stall0 = 1'b0;
					r_next.toggle = 1'b1;
					r_next.st = ep0ar_pkg::D_IDLE;
					r_next.rsp_code = ep0ar_pkg::RSP_ACK;
				end
				ep0ar_pkg::TOK_IN: begin
					if (r_reg.stall0) begin
						// Stall answers once, then clears itself
						r_next.stall0 = 1'b0;
						r_next.st = ep0ar_pkg::D_IDLE;
						r_next.rsp_code = ep0ar_pkg::RSP_STALL;
					end else if (r_reg.st == ep0ar_pkg::D_STATUS) begin
						// Data ran out on a full packet: close with an empty one
						r_next.rsp_code = ep0ar_pkg::RSP_ZLP;
					end else if (r_reg.st == ep0ar_pkg::D_WAIT_IN && !r_reg.handshake_nak_hold) begin
						r_next.rsp_valid = 1'b0;
						r_next.base = r_reg.addr;
						r_next.pkt_cnt = 7'h00;
						r_next.pkt_len = (r_reg.remain >= ep0ar_pkg::PKT_MAX_W) ?
							ep0ar_pkg::PKT_MAX : r_reg.remain[6:0];
						r_next.st = ep0ar_pkg::D_FILL;
					end
				end
				ep0ar_pkg::TOK_STATUS: begin
					if (r_reg.stall0) begin
						r_next.stall0 = 1'b0;
						r_next.st = ep0ar_pkg::D_IDLE;
						r_next.rsp_code = ep0ar_pkg::RSP_STALL;
					end else if (!r_reg.handshake_nak_hold) begin
						r_next.rsp_code = ep0ar_pkg::RSP_ACK;
						r_next.toggle = 1'b1;
						r_next.st = ep0ar_pkg::D_IDLE;
					end
				end
				ep0ar_pkg::TOK_ACK: begin
					r_next.rsp_valid = 1'b0;
					if (r_reg.st == ep0ar_pkg::D_WAIT_HS) begin
						r_next.toggle = ~r_reg.toggle;
						r_next.in_irq = 1'b1;
						r_next.remain = r_reg.remain - {9'h000, r_reg.pkt_len};
						r_next.st = (r_next.remain == 16'h0000) ? ep0ar_pkg::D_STATUS : ep0ar_pkg::D_WAIT_IN;
					end
				end
				ep0ar_pkg::TOK_ERR: begin
					r_next.rsp_valid = 1'b0;
					// Rewind to the packet start; toggle stays so the repeat matches
					if (r_reg.st == ep0ar_pkg::D_WAIT_HS) begin
						r_next.addr = r_reg.base;
						r_next.st = ep0ar_pkg::D_WAIT_IN;
					end
				end
				default: r_next.rsp_valid = 1'b0;
			endcase
		end
	end

	// Register the whole state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r_reg <= '0;
			r_reg.st <= ep0ar_pkg::D_IDLE;
			r_reg.ptr <= ep0ar_pkg::PTR_RST;
			r_reg.stall_out <= ep0ar_pkg::STALL_RST;
			r_reg.stall_in <= ep0ar_pkg::STALL_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Firmware writes into the table and the IN buffer
	always_ff @(posedge clk_sys) begin
		if (fw_wr && fw_addr < ep0ar_pkg::REG_PTR_HI) begin
			desc_ram[fw_addr[7:0]] <= fw_wdata;
		end
		if (fw_wr && fw_addr >= ep0ar_pkg::INBUF_BASE && fw_addr < ep0ar_pkg::INBUF_BASE + 9'h040) begin
			in_buf[fw_addr[5:0]] <= fw_wdata;
		end
	end
endmodule : ep0ar_device

/* File: hw/ep0ar_host.sv */
`timescale 1ns/10ps
module ep0ar_host (
	input wire logic clk_sys,
	input wire logic sys_rst,
	ep0ar_link_if.hst link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [63:0] cmd_setup,
	input wire logic err_inject,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic done,
	output logic done_stall,
	output logic [15:0] rx_total
);
	typedef struct packed {
		ep0ar_pkg::ep0ar_hstate_t st;
		logic [63:0] setup; // Request in flight
		logic [15:0] total; // Accepted data bytes
		logic [6:0] cnt; // Bytes in current packet
		logic bad; // Current packet is to be rejected
		logic tok_valid;
		ep0ar_pkg::ep0ar_tok_t tok_kind;
		logic done;
		logic stall;
	} ep0ar_host_t;
	ep0ar_host_t r_reg;
	ep0ar_host_t r_next;
	logic beat;
	logic [15:0] got;

	assign cmd_ready = (r_reg.st == ep0ar_pkg::H_IDLE);
	// A rejected packet is swallowed without reaching the user
	assign link.d2h_ready = (r_reg.st == ep0ar_pkg::H_RX) && (r_reg.bad || rx_ready);
	assign rx_valid = (r_reg.st == ep0ar_pkg::H_RX) && !r_reg.bad && link.d2h_valid;
	assign rx_data = link.d2h_data;
	assign beat = link.d2h_valid && link.d2h_ready;
	assign got = r_reg.total + {9'h000, r_reg.cnt} + 16'h0001;
	assign link.tok_valid = r_reg.tok_valid;
	assign link.tok_kind = r_reg.tok_kind;
	assign link.tok_setup = r_reg.setup;
	assign done = r_reg.done;
	assign done_stall = r_reg.stall;
	assign rx_total = r_reg.total;

	// Control transfer sequencing
	always_comb begin
		r_next = r_reg;
		r_next.tok_valid = 1'b0;
		r_next.done = 1'b0;
		case (r_reg.st)
			ep0ar_pkg::H_IDLE: begin
				if (cmd_valid) begin
					r_next.setup = cmd_setup;
					r_next.total = 16'h0000;
					r_next.stall = 1'b0;
					r_next.tok_valid = 1'b1;
					r_next.tok_kind = ep0ar_pkg::TOK_SETUP;
					r_next.st = ep0ar_pkg::H_SETUP;
				end
			end
			ep0ar_pkg::H_SETUP: begin
				if (link.rsp_valid) begin
					// Data stage only for device-to-host with a length
					r_next.st = (r_reg.setup[ep0ar_pkg::RT_DIR_IN] && r_reg.setup[63:48] != 16'h0000) ?
						ep0ar_pkg::H_IN : ep0ar_pkg::H_SEND_ST;
				end
			end
			ep0ar_pkg::H_IN: begin
				r_next.tok_valid = 1'b1;
				r_next.tok_kind = ep0ar_pkg::TOK_IN;
				r_next.cnt = 7'h00;
				r_next.bad = err_inject;
				r_next.st = ep0ar_pkg::H_RX;
			end
			ep0ar_pkg::H_RX: begin
				if (link.rsp_valid) begin
					case (link.rsp_code)
						ep0ar_pkg::RSP_NAK: r_next.st = ep0ar_pkg::H_IN;
						ep0ar_pkg::RSP_ZLP: r_next.st = ep0ar_pkg::H_SEND_ST;
						default: begin
							r_next.done = 1'b1;
							r_next.stall = 1'b1;
							r_next.st = ep0ar_pkg::H_IDLE;
						end
					endcase
				end else if (beat) begin
					r_next.cnt = r_reg.cnt + 7'h01;
					if (link.d2h_last) begin
						r_next.tok_valid = 1'b1;
						if (r_reg.bad) begin
							r_next.tok_kind = ep0ar_pkg::TOK_ERR;
							r_next.st = ep0ar_pkg::H_IN;
						end else begin
							r_next.tok_kind = ep0ar_pkg::TOK_ACK;
							r_next.total = got;
							// Short packet or full length ends the data stage
							r_next.st = (r_next.cnt < ep0ar_pkg::PKT_MAX || got >= r_reg.setup[63:48]) ?
								ep0ar_pkg::H_SEND_ST : ep0ar_pkg::H_IN;
						end
					end
				end
			end
			ep0ar_pkg::H_SEND_ST: begin
				r_next.tok_valid = 1'b1;
				r_next.tok_kind = ep0ar_pkg::TOK_STATUS;
				r_next.st = ep0ar_pkg::H_STATUS;
			end
			ep0ar_pkg::H_STATUS: begin
				if (link.rsp_valid) begin
					if (link.rsp_code == ep0ar_pkg::RSP_NAK) begin
						r_next.st = ep0ar_pkg::H_SEND_ST;
					end else begin
						r_next.done = 1'b1;
						r_next.stall = (link.rsp_code == ep0ar_pkg::RSP_STALL);
						r_next.st = ep0ar_pkg::H_IDLE;
					end
				end
			end
			default: r_next.st = ep0ar_pkg::H_IDLE;
		endcase
	end

	// Register the whole state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r_reg <= '0;
			r_reg.st <= ep0ar_pkg::H_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule : ep0ar_host

/* File: dv/ep0ar_properties.sv */
`timescale 1ns/10ps
module ep0ar_properties (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic tok_valid,
	input wire ep0ar_pkg::ep0ar_tok_t tok_kind,
	input wire logic d2h_valid,
	input wire logic d2h_ready,
	input wire logic d2h_last,
	input wire logic d2h_toggle,
	input wire logic rsp_valid,
	input wire ep0ar_pkg::ep0ar_rsp_t rsp_code
);
	logic [6:0] nbytes_reg; // Bytes taken so far in the open packet
	logic sent_reg; // A packet ended and waits for its handshake
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Track packet length and whether a handshake is due
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nbytes_reg <= 7'h00;
			sent_reg <= 1'b0;
		end else begin
			if (d2h_valid && d2h_ready)
				nbytes_reg <= d2h_last ? 7'h00 : nbytes_reg + 7'h01;
			// Among handshakes, only one right after a packet moves the toggle
			if (d2h_valid && d2h_ready && d2h_last)
				sent_reg <= 1'b1;
			else if (tok_valid)
				sent_reg <= 1'b0;
		end
	end
	sequence s_tok(k);
		tok_valid && tok_kind == k;
	endsequence
	sequence s_hs(k);
		s_tok(k) ##0 sent_reg;
	endsequence
	chk_setup_ack: assert property (s_tok(ep0ar_pkg::TOK_SETUP) |=> rsp_valid && rsp_code == ep0ar_pkg::RSP_ACK)
		else $error("setup token not acknowledged");
	chk_setup_toggle: assert property (s_tok(ep0ar_pkg::TOK_SETUP) |=> d2h_toggle)
		else $error("toggle not DATA1 after setup");
	chk_ack_flip: assert property (s_hs(ep0ar_pkg::TOK_ACK) |=> d2h_toggle != $past(d2h_toggle))
		else $error("toggle kept after acknowledged packet");
	chk_err_keep: assert property (s_hs(ep0ar_pkg::TOK_ERR) |=> $stable(d2h_toggle))
		else $error("toggle moved after failed packet");
	chk_pkt_max: assert property (d2h_valid && d2h_ready && nbytes_reg == 7'h3F |-> d2h_last)
		else $error("packet longer than 64 bytes");
	chk_status_rsp: assert property (s_tok(ep0ar_pkg::TOK_STATUS) |=> rsp_valid)
		else $error("status token unanswered");
	chk_in_answer: assert property (s_tok(ep0ar_pkg::TOK_IN) |=> rsp_valid or ##[1:20] d2h_valid)
		else $error("in token unanswered");
	chk_rsp_cause: assert property (rsp_valid |-> $past(tok_valid))
		else $error("answer without token");
	// A fresh SETUP drops any queued bytes of an aborted transfer
	chk_setup_flush: assert property (s_tok(ep0ar_pkg::TOK_SETUP) |=> !d2h_valid)
		else $error("bytes left queued after setup");
endmodule : ep0ar_properties

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic clk_sys, sys_rst, fw_wr, cmd_valid, cmd_ready, err_inject;
	logic rx_valid, rx_ready, done, done_stall;
	logic setup_data_available_irq, ep_zero_in_irq, remote_wakeup_en;
	logic [8:0] fw_addr;
	logic [7:0] fw_wdata, fw_rdata, rx_data;
	logic [63:0] cmd_setup;
	logic [15:0] rx_total;
	logic [7:0] tbl [256]; // Model of the descriptor table
	logic [7:0] ib [64]; // Model of the IN buffer
	logic [7:0] q [$]; // Bytes seen by the host user
	int fails = 0;
	int num_checks = 0;
	int n_done = 0; // Done pulses seen; counted so a pulse inside firmware writes is not missed
	int n_in_irq = 0; // Endpoint-zero IN events seen
	ep0ar_link_if link (.clk_sys);
	ep0ar_device ep0ar_device_i (.clk_sys, .sys_rst, .link, .fw_wr, .fw_addr, .fw_wdata, .fw_rdata,
		.setup_data_available_irq, .ep_zero_in_irq, .remote_wakeup_en);
	ep0ar_host ep0ar_host_i (.clk_sys, .sys_rst, .link, .cmd_valid, .cmd_ready, .cmd_setup, .err_inject,
		.rx_valid, .rx_ready, .rx_data, .done, .done_stall, .rx_total);
	ep0ar_properties ep0ar_properties_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tok_valid(link.tok_valid),
		.tok_kind(link.tok_kind), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready),
		.d2h_last(link.d2h_last), .d2h_toggle(link.d2h_toggle), .rsp_valid(link.rsp_valid),
		.rsp_code(link.rsp_code));
	// 20 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Count one-cycle pulses on the falling edge, where they are settled
	always @(negedge clk_sys) begin
		if (done === 1'b1)
			n_done++;
		if (ep_zero_in_irq === 1'b1)
			n_in_irq++;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Inputs always move 2 ns after the edge
	task automatic tick();
		@(posedge clk_sys);
		#2;
	endtask : tick
	// Idle cycle after each write keeps the strobe from being driven twice at once
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		fw_wr = 1'b1;
		fw_addr = a;
		fw_wdata = d;
		tick();
		fw_wr = 1'b0;
		tick();
	endtask : wr
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		fw_addr = a;
		tick();
		d = fw_rdata;
	endtask : rd
	// Shorter of the table length and the requested length
	function automatic logic [15:0] exp_len(input logic [7:0] p, input logic [15:0] w);
		logic [15:0] t;
		t = (tbl[p + 8'h01] == 8'h02) ? {tbl[p + 8'h03], tbl[p + 8'h02]} : {8'h00, tbl[p]};
		return (t < w) ? t : w;
	endfunction : exp_len
	// One control transfer; mode 0 pointer, 1 byte count, 2 stall, 3 no data
	task automatic xfer(input logic [63:0] s, input logic [1:0] mode, input logic [7:0] arg,
		input logic e, input logic [15:0] n);
		logic [7:0] b;
		logic [7:0] h;
		int k;
		int d0;
		int e0;
		q.delete();
		d0 = n_done;
		e0 = n_in_irq;
		cmd_setup = s;
		cmd_valid = 1'b1;
		tick();
		cmd_valid = 1'b0;
		k = 0;
		while (setup_data_available_irq !== 1'b1 && k < 100) begin
			tick();
			k++;
		end
		chk("setup irq", 16'h0001, {15'h0000, setup_data_available_irq});
		for (int i = 0; i < 8; i++) begin
			rd(9'h108 + 9'(i), b);
			chk("setup byte", {8'h00, s[i*8 +: 8]}, {8'h00, b});
		end
		// Firmware side of the request
		case (mode)
			2'h0: begin
				h = 8'($urandom);
				wr(9'h102, 8'h02);
				wr(9'h100, h);
				wr(9'h101, arg);
				rd(9'h100, b);
				chk("ptr high", {8'h00, h}, {8'h00, b});
			end
			2'h1: begin
				wr(9'h102, 8'h02);
				wr(9'h103, arg);
			end
			2'h2: wr(9'h102, 8'h03);
			default: wr(9'h102, 8'h02);
		endcase
		// Host user stalls in bursts so the FIFO fills and refuses
		k = 0;
		while (n_done == d0 && k < 4000) begin
			err_inject = e && k < 150;
			rx_ready = (k % 100 > 30) && 1'($urandom);
			if (rx_valid && rx_ready)
				q.push_back(rx_data);
			tick();
			k++;
		end
		rx_ready = 1'b0;
		err_inject = 1'b0;
		chk("done", 16'h0001, 16'(n_done - d0));
		chk("in irq", 16'((n + 16'h003F) >> 6), 16'(n_in_irq - e0));
		chk("stall", {15'h0000, mode == 2'h2}, {15'h0000, done_stall});
		chk("total", n, rx_total);
		chk("count", n, 16'(q.size()));
		foreach (q[i]) chk("data", {8'h00, mode == 2'h1 ? ib[i] : tbl[arg + 8'(i)]}, {8'h00, q[i]});
		tick();
	endtask : xfer
	initial begin
		repeat (40000) @(posedge clk_sys);
		fails++;
		summarize();
	end
	initial begin
		logic [7:0] b;
		logic [7:0] p;
		logic [15:0] w;
		void'($urandom(32'hF979));
		{sys_rst, fw_wr, cmd_valid, err_inject, rx_ready} = 5'h10;
		fw_addr = 9'h000;
		fw_wdata = 8'h00;
		cmd_setup = 64'h0;
		repeat (6) @(posedge clk_sys);
		#2 sys_rst = 1'b0;
		rd(9'h100, b);
		chk("ptr high rst", 16'h0000, {8'h00, b});
		rd(9'h101, b);
		chk("ptr low rst", 16'h0000, {8'h00, b});
		// Random table with a device, a 91-byte config and a 128-byte vendor entry
		foreach (tbl[i]) tbl[i] = 8'($urandom);
		{tbl[8'h11], tbl[8'h10]} = 16'h0112;
		{tbl[8'h43], tbl[8'h42], tbl[8'h41]} = 24'h005B02;
		{tbl[8'hC1], tbl[8'hC0]} = 16'h0080;
		foreach (tbl[i]) wr(9'(i), tbl[i]);
		xfer(64'h0040_0000_0100_0680, 2'h0, 8'h10, 1'b0, 16'h0012);
		xfer(64'h00FF_0000_0200_0680, 2'h0, 8'h40, 1'b1, 16'h005B);
		xfer(64'h0200_0000_0000_55C0, 2'h0, 8'hC0, 1'b0, 16'h0080);
		xfer(64'h0000_0000_0100_0680, 2'h0, 8'h10, 1'b0, 16'h0000);
		for (int j = 0; j < 4; j++) begin
			p = 8'($urandom);
			w = 16'($urandom % 300);
			xfer({w, 32'h0000_0300, 16'h0680}, 2'h0, p, 1'b0, exp_len(p, w));
		end
		for (int i = 0; i < 10; i++) begin
			ib[i] = 8'($urandom);
			wr(9'h140 + 9'(i), ib[i]);
		end
		xfer(64'h0040_0000_0100_0680, 2'h1, 8'h0A, 1'b0, 16'h000A);
		xfer(64'h0040_0000_0100_0680, 2'h2, 8'h10, 1'b0, 16'h0000);
		xfer(64'h0040_0000_0100_0680, 2'h0, 8'h10, 1'b0, 16'h0012);
		wr(9'h104, 8'h01);
		xfer(64'h0000_0000_0001_0100, 2'h3, 8'h00, 1'b0, 16'h0000);
		chk("wakeup set", 16'h0001, {15'h0000, remote_wakeup_en});
		wr(9'h104, 8'h00);
		chk("wakeup", 16'h0000, {15'h0000, remote_wakeup_en});
		// Status stage leaves DATA1; firmware may only force it back to DATA0
		rd(9'h107, b);
		chk("toggle status", 16'h0001, {8'h00, b});
		wr(9'h107, 8'h01);
		rd(9'h107, b);
		chk("toggle forced", 16'h0000, {8'h00, b});
		wr(9'h106, 8'h08);
		xfer(64'h0000_0083_0000_0102, 2'h3, 8'h00, 1'b0, 16'h0000);
		wr(9'h106, 8'h00);
		rd(9'h106, b);
		chk("in stall", 16'h0000, {8'h00, b});
		summarize();
	end
endmodule : tb_top
